// file: shared/arc_defs.svh
// Register offsets, field positions, reset values and timing figures of the arc protection stage.
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARC_CTRL_OFF     8'h00
`define ARC_PH_THR_OFF   8'h04
`define ARC_RES_THR_OFF  8'h08
`define ARC_RES_SEL_OFF  8'h0c
`define ARC_ZONE0_OFF    8'h10
`define ARC_COND_OFF     8'h20
`define ARC_SENSOR_OFF   8'h24
`define ARC_BLK_INFO_OFF 8'h28
`define ARC_BLK_IA_OFF   8'h2c
`define ARC_BLK_IB_OFF   8'h30
`define ARC_BLK_IC_OFF   8'h34
`define ARC_BLK_I0_OFF   8'h38
`define ARC_STAMP_OFF    8'h3c

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define ARC_CTRL_FORCE_EN  0
`define ARC_CTRL_FORCE_BLK 1
`define ARC_ZONE_CFG_W     13
`define ARC_COND_VALID     3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ARC_PH_THR_RST  16'h0078
`define ARC_RES_THR_RST 16'h0078

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ARC_CLK_NS   10
`define ARC_STAMP_NS 1000000

`endif

// file: shared/arc_pkg.sv
// Types shared by the arc protection stage and its zone logic.
package arc_pkg;

  typedef enum logic [1:0] {
    DI_OFF     = 2'b00,
    DI_LIGHT   = 2'b01,
    DI_CURRENT = 2'b10
  } di_mode_t;

  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_ONE  = 2'b01,
    RES_TWO  = 2'b10
  } res_sel_t;

  typedef struct packed {
    di_mode_t    di_mode;
    logic [3:0]  pres;
    logic [3:0]  light;
    logic        res_en;
    logic        ph_en;
    logic        en;
  } zone_cfg_t;

endpackage

// file: shared/zone_if.sv
// Carrier between the stage and one zone's pick-up logic.
`timescale 1ns/1ns
interface zone_if;
  arc_pkg::zone_cfg_t cfg;
  logic               pickup;

  modport stage (output cfg, input pickup);
  modport zone (input cfg, output pickup);
endinterface

// file: core/arc_zone_logic.sv
// Pick-up decision of one protection zone.
`timescale 1ns/1ns
module arc_zone_logic (
  zone_if.zone      zb,
  input wire logic [3:0] light,
  input wire logic [3:0] pres,
  input wire logic       di,
  input wire logic       ph_q,
  input wire logic       res_q
);

  wire logic sens_hit;
  wire logic cur_ok;
  wire logic sens_ok;
  wire logic di_light;
  wire logic di_cur;
  wire logic mode_free;

  assign sens_hit = |(light & zb.cfg.light) | |(pres & zb.cfg.pres);
  assign cur_ok   = (~zb.cfg.ph_en | ph_q) & (~zb.cfg.res_en | res_q);
  assign sens_ok  = sens_hit & cur_ok;

  // In current-qualified mode the sensors only count together with the input line.
  assign mode_free = zb.cfg.di_mode != arc_pkg::DI_CURRENT;
  assign di_light  = zb.cfg.di_mode == arc_pkg::DI_LIGHT && di;
  assign di_cur    = zb.cfg.di_mode == arc_pkg::DI_CURRENT && di && sens_ok;

  assign zb.pickup = zb.cfg.en & ((sens_ok & mode_free) | di_light | di_cur);

endmodule

// file: core/arc_protection_stage.sv
// Arc protection stage: four zones, blocking, status codes and event stream behind APB.
`timescale 1ns/1ns
`include "arc_defs.svh"
module arc_protection_stage #(
  parameter int CUR_W     = 16,
  parameter int ZONES     = 4,
  parameter int MS_CYCLES = `ARC_STAMP_NS / `ARC_CLK_NS
) (
  input  wire  logic             clk,
  input  wire  logic             sys_rst,
  input  wire  logic             psel,
  input  wire  logic             penable,
  input  wire  logic             pwrite,
  input  wire  logic [7:0]       paddr,
  input  wire  logic [31:0]      pwdata,
  output logic       [31:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire  logic             cycle_tick,
  input  wire  logic [CUR_W-1:0] cur_a,
  input  wire  logic [CUR_W-1:0] cur_b,
  input  wire  logic [CUR_W-1:0] cur_c,
  input  wire  logic [CUR_W-1:0] residual_input_one,
  input  wire  logic [CUR_W-1:0] residual_input_two,
  input  wire  logic [3:0]       light_det,
  input  wire  logic [3:0]       pres_det,
  input  wire  logic             digital_input_line,
  input  wire  logic             block_in,
  input  wire  logic [3:0]       sensor_fault,
  input  wire  logic             io_fault,
  output logic [ZONES-1:0]       trip,
  output logic [ZONES-1:0]       blocked,
  output logic                   ph_start,
  output logic                   res_start,
  output logic                   disp_evt,
  output logic                   blk_evt,
  output logic                   evt_valid,
  output logic [4:0]             evt_index,
  output logic                   evt_on,
  output logic [31:0]            evt_stamp
);

  localparam int EV_N = 26;
  localparam int MS_W = $clog2(MS_CYCLES);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic                   force_en_r;
  logic                   force_sw_r;
  logic [CUR_W-1:0]       ph_thr_r;
  logic [CUR_W-1:0]       res_thr_r;
  arc_pkg::res_sel_t      res_sel_r;
  arc_pkg::zone_cfg_t     cfg_r [ZONES];
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic [3:0]             cond_r;
  logic [17:0]            sens_r;
  logic [3:0]             blk_info_r;
  logic [CUR_W-1:0]       blk_cur_r [4];
  logic [31:0]            stamp_r;

  wire logic        setup;
  wire logic        wr;
  wire logic        hit;
  wire logic        zsel;
  wire logic [1:0]  zidx;
  logic      [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready_r & pwrite;
  assign hit   = paddr[1:0] == 2'h0 && paddr <= `ARC_STAMP_OFF;
  assign zsel  = paddr[7:4] == 4'(`ARC_ZONE0_OFF >> 4);
  assign zidx  = paddr[3:2];

  always_comb begin
    rd_mux = 32'h0;
    if (zsel) begin
      rd_mux = {19'h0, cfg_r[zidx]};
    end else begin
      unique case (paddr)
        `ARC_CTRL_OFF:     rd_mux = {30'h0, force_sw_r, force_en_r};
        `ARC_PH_THR_OFF:   rd_mux = 32'(ph_thr_r);
        `ARC_RES_THR_OFF:  rd_mux = 32'(res_thr_r);
        `ARC_RES_SEL_OFF:  rd_mux = {30'h0, res_sel_r};
        `ARC_COND_OFF:     rd_mux = {28'h0, cond_r};
        `ARC_SENSOR_OFF:   rd_mux = {14'h0, sens_r};
        `ARC_BLK_INFO_OFF: rd_mux = {28'h0, blk_info_r};
        `ARC_BLK_IA_OFF:   rd_mux = 32'(blk_cur_r[0]);
        `ARC_BLK_IB_OFF:   rd_mux = 32'(blk_cur_r[1]);
        `ARC_BLK_IC_OFF:   rd_mux = 32'(blk_cur_r[2]);
        `ARC_BLK_I0_OFF:   rd_mux = 32'(blk_cur_r[3]);
        `ARC_STAMP_OFF:    rd_mux = stamp_r;
        default:           rd_mux = 32'h0;
      endcase
    end
  end

  // The answer is always one access cycle: pready rises with penable.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      force_en_r <= 1'b0;
      force_sw_r <= 1'b0;
      ph_thr_r   <= CUR_W'(`ARC_PH_THR_RST);
      res_thr_r  <= CUR_W'(`ARC_RES_THR_RST);
      res_sel_r  <= arc_pkg::RES_NONE;
      for (int i = 0; i < ZONES; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr) begin
      if (zsel) begin
        cfg_r[zidx] <= arc_pkg::zone_cfg_t'(pwdata[`ARC_ZONE_CFG_W-1:0]);
      end
      if (paddr == `ARC_CTRL_OFF) begin
        force_en_r <= pwdata[`ARC_CTRL_FORCE_EN];
        force_sw_r <= pwdata[`ARC_CTRL_FORCE_BLK];
      end
      if (paddr == `ARC_PH_THR_OFF) begin
        ph_thr_r <= pwdata[CUR_W-1:0];
      end
      if (paddr == `ARC_RES_THR_OFF) begin
        res_thr_r <= pwdata[CUR_W-1:0];
      end
      if (paddr == `ARC_RES_SEL_OFF) begin
        res_sel_r <= arc_pkg::res_sel_t'(pwdata[1:0]);
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Current qualifiers and zone pick-up
  // ----------------------------------------------------------------
  wire logic             ph_q;
  wire logic             res_q;
  wire logic [CUR_W-1:0] res_cur;
  wire logic [ZONES-1:0] pick;
  wire logic [ZONES-1:0] zone_en;

  assign ph_q    = cur_a > ph_thr_r || cur_b > ph_thr_r || cur_c > ph_thr_r;
  assign res_cur = res_sel_r == arc_pkg::RES_ONE ? residual_input_one : residual_input_two;
  // Code 3 is not a source; it is treated like no source so the qualifier stays off.
  assign res_q   = (res_sel_r == arc_pkg::RES_ONE || res_sel_r == arc_pkg::RES_TWO) && res_cur > res_thr_r;

  zone_if zif [ZONES] ();

  for (genvar g = 0; g < ZONES; g++) begin : g_zone
    assign zif[g].cfg = cfg_r[g];
    assign pick[g]    = zif[g].pickup;
    assign zone_en[g] = cfg_r[g].en;
    arc_zone_logic u_zone (
      .zb    (zif[g]),
      .light (light_det),
      .pres  (pres_det),
      .di    (digital_input_line),
      .ph_q  (ph_q),
      .res_q (res_q)
    );
  end

  // ----------------------------------------------------------------
  // Blocking and zone outputs
  // ----------------------------------------------------------------
  logic             blk_s_r;
  logic [ZONES-1:0] trip_r;
  logic [ZONES-1:0] blocked_r;
  logic             disp_evt_r;
  logic             blk_evt_r;
  logic             ph_start_r;
  logic             res_start_r;

  wire logic             blk_src;
  wire logic             blk_s_nxt;
  wire logic [ZONES-1:0] trip_nxt;
  wire logic [ZONES-1:0] blocked_nxt;
  wire logic [ZONES-1:0] blk_new;
  logic      [1:0]       blk_zone;
  logic      [3:0]       cond_nxt;

  assign blk_src   = force_en_r ? force_sw_r : block_in;
  assign blk_s_nxt = cycle_tick ? blk_src : blk_s_r;
  // A pick-up that met blocking stays blocked until it drops, so it never turns into a trip later.
  assign blocked_nxt = (cycle_tick ? pick & (blocked_r | {ZONES{blk_s_nxt}}) : blocked_r) & zone_en;
  assign trip_nxt    = (cycle_tick ? pick & ~blocked_nxt & {ZONES{~blk_s_nxt}} : trip_r) & zone_en;
  assign blk_new     = blocked_nxt & ~blocked_r;

  always_comb begin
    blk_zone = 2'h0;
    cond_nxt = 4'h0;
    for (int i = ZONES - 1; i >= 0; i--) begin
      if (blk_new[i]) begin
        blk_zone = 2'(i);
      end
      if (trip_nxt[i] | blocked_nxt[i]) begin
        cond_nxt = {1'b1, 2'(i), blocked_nxt[i]};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_s_r     <= 1'b0;
      trip_r      <= '0;
      blocked_r   <= '0;
      cond_r      <= 4'h0;
      disp_evt_r  <= 1'b0;
      blk_evt_r   <= 1'b0;
      ph_start_r  <= 1'b0;
      res_start_r <= 1'b0;
    end else begin
      blk_s_r     <= blk_s_nxt;
      trip_r      <= trip_nxt;
      blocked_r   <= blocked_nxt;
      cond_r      <= cond_nxt;
      disp_evt_r  <= |blk_new;
      blk_evt_r   <= |blk_new;
      ph_start_r  <= ph_q & ~blk_s_nxt;
      res_start_r <= res_q & ~blk_s_nxt;
    end
  end

  // Currents and fault type are frozen at the blocking moment for software to read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_info_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        blk_cur_r[i] <= '0;
      end
    end else if (|blk_new) begin
      blk_info_r   <= {res_q, ph_q, blk_zone};
      blk_cur_r[0] <= cur_a;
      blk_cur_r[1] <= cur_b;
      blk_cur_r[2] <= cur_c;
      blk_cur_r[3] <= res_cur;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sens_r <= 18'h0;
    end else begin
      sens_r <= {io_fault, sensor_fault, digital_input_line,
                 pres_det[3], light_det[3], pres_det[2], light_det[2],
                 pres_det[1], light_det[1], pres_det[0], light_det[0],
                 res_q & ~blk_s_nxt, res_q & blk_s_nxt, ph_q & ~blk_s_nxt, ph_q & blk_s_nxt};
    end
  end

  assign trip      = trip_r;
  assign blocked   = blocked_r;
  assign ph_start  = ph_start_r;
  assign res_start = res_start_r;
  assign disp_evt  = disp_evt_r;
  assign blk_evt   = blk_evt_r;

  // ----------------------------------------------------------------
  // Millisecond stamp and ON/OFF event stream
  // ----------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt_r;
  logic [EV_N-1:0] rep_r;
  logic            evt_valid_r;
  logic [4:0]      evt_index_r;
  logic            evt_on_r;
  logic [31:0]     evt_stamp_r;

  wire logic [EV_N-1:0] ev_vec;
  wire logic [EV_N-1:0] diff;
  wire logic            ms_wrap;
  logic      [4:0]      pick_idx;

  assign ms_wrap = ms_cnt_r == MS_W'(MS_CYCLES - 1);
  assign ev_vec  = {sens_r, blocked_r[3], trip_r[3], blocked_r[2], trip_r[2],
                    blocked_r[1], trip_r[1], blocked_r[0], trip_r[0]};
  assign diff    = ev_vec ^ rep_r;

  // Lowest changed signal first; several changes in one cycle go out on consecutive cycles.
  always_comb begin
    pick_idx = 5'h0;
    for (int i = EV_N - 1; i >= 0; i--) begin
      if (diff[i]) begin
        pick_idx = 5'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_cnt_r <= '0;
      stamp_r  <= 32'h0;
    end else begin
      ms_cnt_r <= ms_wrap ? '0 : ms_cnt_r + MS_W'(1);
      stamp_r  <= ms_wrap ? stamp_r + 32'h1 : stamp_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rep_r       <= '0;
      evt_valid_r <= 1'b0;
      evt_index_r <= 5'h0;
      evt_on_r    <= 1'b0;
      evt_stamp_r <= 32'h0;
    end else begin
      evt_valid_r <= |diff;
      if (|diff) begin
        rep_r[pick_idx] <= ev_vec[pick_idx];
        evt_index_r     <= pick_idx;
        evt_on_r        <= ev_vec[pick_idx];
        evt_stamp_r     <= stamp_r;
      end
    end
  end

  assign evt_valid = evt_valid_r;
  assign evt_index = evt_index_r;
  assign evt_on    = evt_on_r;
  assign evt_stamp = evt_stamp_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_zone_off_quiet: assert property (((trip_r | blocked_r) & ~zone_en) == '0 || $changed(zone_en))
    else $error("disabled zone shows trip or blocked");
  a_trip_unblocked: assert property (trip_r != '0 |-> !blk_s_r)
    else $error("trip while blocking sampled active");
  a_block_held: assert property (!cycle_tick |=> $stable(blk_s_r))
    else $error("blocking sample moved inside a cycle");
  a_blocked_not_trip: assert property ((blocked_r & trip_r) == '0)
    else $error("zone both tripped and blocked");
  a_block_event: assert property ($rose(|blocked_r) |-> blk_evt_r && disp_evt_r)
    else $error("blocking without events");
  a_force_switch: assert property (cycle_tick && force_en_r |=> blk_s_r == $past(force_sw_r))
    else $error("forced blocking not taken");
  a_res_none: assert property (res_sel_r == arc_pkg::RES_NONE |-> !res_q)
    else $error("residual qualifier without source");
  a_ph_qualifier: assert property (cur_a > ph_thr_r |=> sens_r[0] || sens_r[1])
    else $error("phase qualifier missed");
  a_cond_code: assert property (trip_r[0] |-> cond_r == 4'h8)
    else $error("wrong condition code for zone one trip");
  a_event_pending: assert property (diff != '0 |=> evt_valid_r ##0 evt_index_r == $past(pick_idx))
    else $error("signal change without event");

  c_trip: cover property ($rose(trip_r[0]));
  c_blocked: cover property ($rose(blocked_r[3]));
  c_forced_block: cover property (force_en_r && force_sw_r && $rose(|blocked_r));
  c_event_off: cover property (evt_valid_r && !evt_on_r);

endmodule

// file: tb/arc_sensor_partner.sv
// Model of the sensor channels and blocking line that feed the arc protection stage.
`timescale 1ns/1ns
module arc_sensor_partner (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] c_light,
  input  wire logic [3:0] c_pres,
  input  wire logic       c_di,
  input  wire logic       c_blk,
  input  wire logic [3:0] c_fault,
  input  wire logic       c_io,
  output logic      [3:0] light_det,
  output logic      [3:0] pres_det,
  output logic            di_line,
  output logic            block_line,
  output logic      [3:0] sensor_fault,
  output logic            io_fault
);
  // Detections reach the pins one clock after the bench asks, like a real filter stage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {light_det, pres_det, di_line, sensor_fault, io_fault} <= '0;
      block_line <= 1'b0;
    end else begin
      {light_det, pres_det, di_line, sensor_fault, io_fault} <= {c_light, c_pres, c_di, c_fault, c_io};
      block_line <= c_blk;
    end
  end
endmodule

// file: tb/arc_protection_stage_bench.sv
// Self-checking bench of the arc protection stage.
`timescale 1ns/1ns
`include "arc_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module arc_protection_stage_bench;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, cycle_tick = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, c_di = 0, c_blk = 0, c_io = 0, di_w, blk_w, io_w;
  logic [15:0] cur_a = '0, res1 = '0, res2 = '0;
  logic [3:0] c_light = '0, c_pres = '0, c_fault = '0, light_w, pres_w, sf_w, trip, blocked;
  logic ph_start, res_start, disp_evt, blk_evt, evt_valid, evt_on;
  logic [4:0] evt_index;
  logic [31:0] evt_stamp;
  int bad_count = 0, n_compared = 0, e_on = 0, e_off = 0, n_blk = 0, n_disp = 0, cyc = 0;
  // Clock cycles per millisecond stamp step in this simulation.
  localparam int MS = 10;

  always #5 clk = ~clk;

  arc_protection_stage #(.MS_CYCLES(MS)) u_arc_protection_stage (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_tick(cycle_tick),
    .cur_a(cur_a), .cur_b(cur_a), .cur_c(cur_a), .residual_input_one(res1), .residual_input_two(res2),
    .light_det(light_w), .pres_det(pres_w), .digital_input_line(di_w), .block_in(blk_w),
    .sensor_fault(sf_w), .io_fault(io_w), .trip(trip), .blocked(blocked), .ph_start(ph_start),
    .res_start(res_start), .disp_evt(disp_evt), .blk_evt(blk_evt), .evt_valid(evt_valid),
    .evt_index(evt_index), .evt_on(evt_on), .evt_stamp(evt_stamp));

  arc_sensor_partner u_arc_sensor_partner (
    .clk(clk), .sys_rst(sys_rst), .c_light(c_light), .c_pres(c_pres), .c_di(c_di), .c_blk(c_blk),
    .c_fault(c_fault), .c_io(c_io), .light_det(light_w), .pres_det(pres_w), .di_line(di_w),
    .block_line(blk_w), .sensor_fault(sf_w), .io_fault(io_w));

  always @(posedge clk) begin
    if (evt_valid === 1'b1 && evt_index === 5'h00) begin
      // The event was captured one edge earlier, from the stamp of the edge before that.
      `CHK("evt stamp", 32'((cyc - 1) / MS), evt_stamp)
      if (evt_on === 1'b1) e_on++;
      else e_off++;
    end
    if (blk_evt === 1'b1) n_blk++;
    if (disp_evt === 1'b1) n_disp++;
    if (sys_rst === 1'b0) cyc++;
  end

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The wait for pready is bounded so a dead slave ends the run instead of hanging it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin bad_count++; complete_run(); end
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge, so the next call never drives psel again in this time step.
    @(posedge clk);
  endtask

  task automatic tick();
    repeat (2) @(posedge clk);
    cycle_tick <= 1'b1;
    @(posedge clk);
    cycle_tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Zone word: {input mode, pressure enables, light enables, residual, phase, zone enable}.
  function automatic logic [31:0] zc(input logic [1:0] di, input logic [3:0] pr, input logic [3:0] li,
                                     input logic [2:0] f);
    zc = {19'h0, di, pr, li, f};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    apb(1'b0, `ARC_ZONE0_OFF + 8'h0c, '0); `CHK("zone4 cfg", 32'h0, rdat)
    apb(1'b0, `ARC_RES_SEL_OFF, '0); `CHK("res sel", 32'h0, rdat)
    apb(1'b0, `ARC_PH_THR_OFF, '0); `CHK("ph thr", 32'h78, rdat)
    apb(1'b0, 8'h40, '0); `CHK("unmapped err", 1'b1, rerr)
    c_light <= 4'hf; c_pres <= 4'hf; c_di <= 1'b1; c_blk <= 1'b1;
    tick();
    `CHK("disabled out", 8'h0, {trip, blocked})
    c_light <= '0; c_pres <= '0; c_di <= 1'b0; c_blk <= 1'b0;
  endtask

  task automatic light_trip_and_block();
    apb(1'b1, `ARC_ZONE0_OFF, zc(2'd0, 4'h0, 4'h1, 3'b001));
    c_light <= 4'h1;
    tick();
    `CHK("z1 trip", 4'h1, trip)
    `CHK("trip event", 1, e_on)
    apb(1'b0, `ARC_COND_OFF, '0); `CHK("cond trip", 32'h8, rdat)
    c_blk <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("held blk", 8'h10, {trip, blocked})
    c_blk <= 1'b0; c_light <= '0;
    tick();
    `CHK("trip off event", 1, e_off)
    c_blk <= 1'b1; c_light <= 4'h1;
    tick();
    `CHK("blocked z1", 8'h01, {trip, blocked})
    `CHK("blk events", 2, n_blk + n_disp)
    apb(1'b0, `ARC_COND_OFF, '0); `CHK("cond blk", 32'h9, rdat)
    c_blk <= 1'b0; c_light <= '0;
    tick();
    apb(1'b1, `ARC_CTRL_OFF, 32'h3);
    c_light <= 4'h1;
    tick();
    `CHK("forced blk", 8'h01, {trip, blocked})
    apb(1'b1, `ARC_ZONE0_OFF, 32'h0);
    @(posedge clk);
    `CHK("disabled mid", 8'h0, {trip, blocked})
    apb(1'b1, `ARC_CTRL_OFF, 32'h0);
    c_light <= '0;
    tick();
  endtask

  task automatic pressure_and_input();
    apb(1'b1, `ARC_ZONE0_OFF + 8'h04, zc(2'd0, 4'h2, 4'h0, 3'b001));
    c_pres <= 4'hd;
    tick();
    `CHK("other pres", 4'h0, trip)
    c_pres <= 4'h2;
    tick();
    `CHK("pres trip", 4'h2, trip)
    c_pres <= '0;
    apb(1'b1, `ARC_ZONE0_OFF + 8'h08, zc(2'd1, 4'h0, 4'h4, 3'b001));
    c_di <= 1'b1; c_io <= 1'b1; c_fault <= 4'h1;
    tick();
    `CHK("di light", 4'h4, trip)
    apb(1'b0, `ARC_SENSOR_OFF, '0); `CHK("sensor stat", 32'h23000, rdat)
    apb(1'b1, `ARC_ZONE0_OFF + 8'h08, zc(2'd2, 4'h0, 4'h4, 3'b001));
    c_io <= 1'b0; c_fault <= '0;
    tick();
    `CHK("di alone", 4'h0, trip)
    c_light <= 4'h4;
    tick();
    `CHK("di and light", 4'h4, trip)
    c_di <= 1'b0;
    tick();
    `CHK("light no di", 4'h0, trip)
    c_light <= '0;
  endtask

  task automatic current_qualifiers();
    apb(1'b1, `ARC_ZONE0_OFF + 8'h0c, zc(2'd0, 4'h0, 4'h8, 3'b011));
    c_light <= 4'h8; cur_a <= 16'h0078;
    tick();
    `CHK("ph at thr", 4'h0, trip)
    cur_a <= 16'h0079;
    tick();
    `CHK("ph above", 4'h8, trip)
    `CHK("ph start", 1'b1, ph_start)
    cur_a <= '0; c_light <= '0;
    apb(1'b1, `ARC_ZONE0_OFF + 8'h04, zc(2'd0, 4'h2, 4'h0, 3'b101));
    c_pres <= 4'h2; res1 <= 16'h0079; res2 <= 16'h0079;
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `ARC_RES_SEL_OFF, 32'(s));
      tick();
      `CHK("res sel trip", s != 0, trip[1])
      `CHK("res start", s != 0, res_start)
    end
    res2 <= '0;
    tick();
    `CHK("res below", 1'b0, trip[1])
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    reset_values();
    light_trip_and_block();
    pressure_and_input();
    current_qualifiers();
    complete_run();
  end
endmodule
